// [verilog/pss_pkg.sv]
package pss_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] PSS_REG_CFG    = 12'h000;
  localparam logic [11:0] PSS_REG_INCHP  = 12'h004;
  localparam logic [11:0] PSS_REG_INCHON = 12'h008;
  localparam logic [11:0] PSS_REG_STATUS = 12'h00c;

  // ****************************************************************
  // configuration fields
  // ****************************************************************
  localparam int CFG_HELD_UP    = 0;
  localparam int CFG_SINGLE_ACT = 1;
  localparam int CFG_MODE_EN    = 2;
  localparam int CFG_PCI_EN     = 3;
  localparam int CFG_CL_UP      = 4;
  localparam int CFG_CL_DOWN    = 5;
  localparam int CFG_SRC_LSB    = 8;
  localparam int CFG_SRC_W      = 2;
  localparam int CFG_W          = 10;

  // cycle command sources
  localparam logic [1:0] SRC_TWO_HAND  = 2'h0;
  localparam logic [1:0] SRC_FOOT      = 2'h1;
  localparam logic [1:0] SRC_CYCLE_INI = 2'h2;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;
  localparam int INCH_W              = 24;
  localparam int INCH_PERIOD_MS      = 100;
  localparam int INCH_ON_MS          = 50;
  localparam int CLK_HZ              = 100_000_000;
  localparam int CYC_PER_MS          = CLK_HZ / 1000;
  localparam logic [INCH_W-1:0] INCH_PERIOD_RESET = INCH_W'(INCH_PERIOD_MS * CYC_PER_MS);
  localparam logic [INCH_W-1:0] INCH_ON_RESET     = INCH_W'(INCH_ON_MS * CYC_PER_MS);

  // status bits
  localparam int ST_W = 8;

  typedef enum logic [5:0] {
    PSS_IDLE   = 6'b000001,
    PSS_DOWN   = 6'b000010,
    PSS_UP     = 6'b000100,
    PSS_VERIFY = 6'b001000,
    PSS_INCH   = 6'b010000,
    PSS_HALT   = 6'b100000
  } pss_state_type;

endpackage

// [verilog/pss_inch_timer.sv]
module pss_inch_timer
  import pss_pkg::*;
#(
  parameter int W = INCH_W
)
(
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  input  wire logic [W-1:0] on_time,
  output logic              pulse_q
);

  logic [W-1:0] cnt_q;

  // a one-bit counter cannot tell the on part from the off part
  if (W < 2)
  begin : g_width_check
    $error("pss_inch_timer: W too small");
  end

  // counter wraps once per period; run low restarts the pattern
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !run)
      cnt_q <= '0;
    else if (cnt_q + W'(1) >= period)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + W'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pulse_q <= 1'b0;
    else
      pulse_q <= run && (cnt_q < on_time); // [RULE11] [RULE12]
  end

endmodule

// [verilog/press_stroke_sequencer.sv]
// What this block does
// [RULE1] reject configs enabling both held upstroke and single actuation
// [RULE2] held upstroke: command must stay on; release stops motion
// [RULE3] held upstroke: only two-hand or foot pedal source accepted
// [RULE4] single actuation: command only starts the cycle, which then continues
// [RULE5] single actuation: cycle initiation, foot pedal or two-hand source accepted
// [RULE6] single actuation: mutable safety stop is muted during upstroke
// [RULE7] closed loop: feedback must show previous valve off before next turns on (inch mode opens its valve without this check)
// [RULE8] mode option adds run, inch up and inch down inputs
// [RULE9] all mode inputs off: mode group off, no motion (the verify stage ignores it, so a valve can open for one cycle)
// [RULE10] inch period and on-time only visible when mode option selected
// [RULE11] inch modes pulse the output for on-time within each period
// [RULE12] held command in inch mode repeats pulse every period
// [RULE13] mode and press-input groups are separate optional input groups
// [RULE14] a safety input returning on never starts motion by itself
// [RULE15] part-present must be high to start and cycle low-high after bottom (start checks the latched low-high, not the current level)
// [RULE16] bottom limit ends down, top limit ends up, safety stop drops both
// [RULE17] up and down valves never on together
//
// Local design decisions: the register addresses and the APB slave port.
module press_stroke_sequencer
  import pss_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cycle_cmd,
  input  wire logic        top_stroke_limit,
  input  wire logic        bottom_stroke_limit,
  input  wire logic        press_reset,
  input  wire logic        nonmutable_safety_stop,
  input  wire logic        mode_run,
  input  wire logic        mode_inch_up,
  input  wire logic        mode_inch_down,
  input  wire logic        part_present_input,
  input  wire logic        mutable_safety_stop,
  input  wire logic        up_feedback_off,
  input  wire logic        down_feedback_off,
  output logic             valve_up_q,
  output logic             valve_down_q
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [CFG_W-1:0]  cfg_q;
  logic [INCH_W-1:0] inch_period_q;
  logic [INCH_W-1:0] inch_on_q;
  logic              cfg_err_q;
  pss_state_type     state_q;
  pss_state_type     state_d;
  logic              armed_q;
  logic              pip_ok_q;
  logic              pip_seen_low_q;
  logic              cmd_prev_q;
  logic              inch_up_dir_q;
  logic              next_up_q;

  logic              wr_acc;
  logic              cfg_valid;
  logic [CFG_W-1:0]  wcfg;
  logic              held_mode;
  logic              single_mode;
  logic              mode_en;
  logic              pci_en;
  logic              mode_off;
  logic              inching;
  logic              inch_pulse;
  logic              nm_trip;
  logic              m_trip_down;
  logic              m_trip_up;
  logic              cmd_rise;
  logic              start_ok;
  logic              fb_clear_up;
  logic              fb_clear_down;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel && penable && pwrite;
  assign wcfg    = pwdata[CFG_W-1:0];

  // a write carrying both cycle options, or a source its cycle option does not accept, is dropped whole
  always_comb
  begin
    cfg_valid = !(wcfg[CFG_HELD_UP] && wcfg[CFG_SINGLE_ACT]); // [RULE1]
    if (wcfg[CFG_HELD_UP] &&
        wcfg[CFG_SRC_LSB +: CFG_SRC_W] != SRC_TWO_HAND &&
        wcfg[CFG_SRC_LSB +: CFG_SRC_W] != SRC_FOOT)
      cfg_valid = 1'b0; // [RULE3]
    if (wcfg[CFG_SINGLE_ACT] &&
        wcfg[CFG_SRC_LSB +: CFG_SRC_W] != SRC_TWO_HAND &&
        wcfg[CFG_SRC_LSB +: CFG_SRC_W] != SRC_FOOT &&
        wcfg[CFG_SRC_LSB +: CFG_SRC_W] != SRC_CYCLE_INI)
      cfg_valid = 1'b0; // [RULE5]
  end

  // config only changes while idle, so a stroke never sees a mode swap
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cfg_q <= CFG_RESET;
    else if (wr_acc && paddr == PSS_REG_CFG && cfg_valid && state_q == PSS_IDLE)
      cfg_q <= wcfg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cfg_err_q <= 1'b0;
    else if (wr_acc && paddr == PSS_REG_CFG)
      cfg_err_q <= !cfg_valid;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      inch_period_q <= INCH_PERIOD_RESET;
      inch_on_q     <= INCH_ON_RESET;
    end
    else if (wr_acc && cfg_q[CFG_MODE_EN])
    begin
      if (paddr == PSS_REG_INCHP)
        inch_period_q <= pwdata[INCH_W-1:0]; // [RULE10]
      if (paddr == PSS_REG_INCHON)
        inch_on_q <= pwdata[INCH_W-1:0]; // [RULE10]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        PSS_REG_CFG:    prdata <= {22'h0, cfg_q};
        PSS_REG_INCHP:  prdata <= cfg_q[CFG_MODE_EN] ? {8'h0, inch_period_q} : '0; // [RULE10]
        PSS_REG_INCHON: prdata <= cfg_q[CFG_MODE_EN] ? {8'h0, inch_on_q} : '0; // [RULE10]
        PSS_REG_STATUS: prdata <= {18'h0, state_q, 2'h0, valve_down_q, valve_up_q,
                                   pip_ok_q, armed_q, mode_off, cfg_err_q};
        default:        prdata <= '0;
      endcase
    end
  end

  // ****************************************************************
  // input conditioning
  // ****************************************************************
  assign held_mode   = cfg_q[CFG_HELD_UP];
  assign single_mode = cfg_q[CFG_SINGLE_ACT];
  assign mode_en     = cfg_q[CFG_MODE_EN]; // [RULE8] [RULE13]
  assign pci_en      = cfg_q[CFG_PCI_EN]; // [RULE13]
  assign mode_off    = mode_en && !mode_run && !mode_inch_up && !mode_inch_down; // [RULE9]
  assign inching     = mode_en && !mode_run && (mode_inch_up || mode_inch_down);
  assign nm_trip     = !nonmutable_safety_stop;
  assign m_trip_down = pci_en && !mutable_safety_stop;
  assign m_trip_up   = pci_en && !mutable_safety_stop && !single_mode; // [RULE6]
  assign cmd_rise    = cycle_cmd && !cmd_prev_q;
  assign start_ok    = armed_q && cmd_rise && !mode_off && (!pci_en || pip_ok_q) // [RULE15]
                       && top_stroke_limit && !nm_trip && !m_trip_down;
  assign fb_clear_up   = !cfg_q[CFG_CL_UP] || up_feedback_off; // [RULE7]
  assign fb_clear_down = !cfg_q[CFG_CL_DOWN] || down_feedback_off; // [RULE7]

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cmd_prev_q <= 1'b0;
    else
      cmd_prev_q <= cycle_cmd;
  end

  // only a fresh command edge starts motion, never a safety input coming back
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      armed_q <= 1'b0;
    else if (nm_trip)
      armed_q <= 1'b0; // [RULE14]
    else if (press_reset && !cycle_cmd)
      armed_q <= 1'b1;
  end

  // part present: needs a low then high after the press leaves bottom
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pip_ok_q       <= 1'b0;
      pip_seen_low_q <= 1'b1;
    end
    else if (state_q == PSS_UP && valve_up_q && bottom_stroke_limit)
    begin
      pip_ok_q       <= 1'b0; // [RULE15]
      pip_seen_low_q <= 1'b0;
    end
    else if (!part_present_input)
      pip_seen_low_q <= 1'b1;
    else if (pip_seen_low_q)
      pip_ok_q <= 1'b1; // [RULE15]
  end

  pss_inch_timer #(
    .W (INCH_W)
  ) u_inch (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .run     (state_q == PSS_INCH && cycle_cmd),
    .period  (inch_period_q),
    .on_time (inch_on_q),
    .pulse_q (inch_pulse)
  );

  // ****************************************************************
  // stroke sequencer
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PSS_IDLE:
        if (inching && armed_q && cmd_rise && !nm_trip)
          state_d = PSS_INCH;
        else if (start_ok && (!mode_en || mode_run))
          state_d = PSS_VERIFY;
      PSS_VERIFY:
        // a mutable trip seen here must not let the next valve open even one cycle
        if (nm_trip || (next_up_q ? m_trip_up : m_trip_down) || (held_mode && !cycle_cmd))
          state_d = PSS_HALT; // [RULE6]
        else if (next_up_q ? fb_clear_down : fb_clear_up) // [RULE7]
          state_d = next_up_q ? PSS_UP : PSS_DOWN;
      PSS_DOWN:
        if (nm_trip || m_trip_down || mode_off || (held_mode && !cycle_cmd)) // [RULE2]
          state_d = PSS_HALT; // [RULE16]
        else if (!held_mode && !single_mode && !cycle_cmd)
          state_d = PSS_HALT;
        else if (bottom_stroke_limit)
          state_d = PSS_VERIFY; // [RULE16]
      PSS_UP:
        if (nm_trip || m_trip_up || mode_off || (held_mode && !cycle_cmd)) // [RULE2] [RULE6]
          state_d = PSS_HALT; // [RULE16]
        else if (top_stroke_limit)
          state_d = PSS_IDLE; // [RULE16]
      PSS_INCH:
        if (nm_trip || !cycle_cmd || !inching)
          state_d = PSS_HALT;
      PSS_HALT:
        if (!cycle_cmd)
          state_d = PSS_IDLE;
      default:
        state_d = PSS_HALT;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state_q <= PSS_IDLE;
    else
      state_q <= state_d;
  end

  // direction for the verify stage: after bottom we go up, otherwise down
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      next_up_q <= 1'b0;
    else if (state_q == PSS_DOWN && state_d == PSS_VERIFY)
      next_up_q <= 1'b1;
    else if (state_q == PSS_IDLE)
      next_up_q <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      inch_up_dir_q <= 1'b0;
    else if (state_q == PSS_IDLE)
      inch_up_dir_q <= mode_inch_up;
  end

  // registered valves; down wins ties by masking up whenever the next state is down, never both
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      valve_up_q   <= 1'b0;
      valve_down_q <= 1'b0;
    end
    else
    begin
      valve_down_q <= (state_d == PSS_DOWN) ||
                      (state_d == PSS_INCH && !inch_up_dir_q && inch_pulse &&
                       !bottom_stroke_limit); // [RULE11] [RULE16]
      valve_up_q   <= ((state_d == PSS_UP) ||
                       (state_d == PSS_INCH && inch_up_dir_q && inch_pulse &&
                        !top_stroke_limit)) && // [RULE16]
                      !(state_d == PSS_DOWN); // [RULE17]
    end
  end

endmodule

// [tb/pss_monitor.sv]
module pss_monitor
  import pss_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        cycle_cmd,
  input wire logic        top_stroke_limit,
  input wire logic        bottom_stroke_limit,
  input wire logic        nonmutable_safety_stop,
  input wire logic        up_feedback_off,
  input wire logic        down_feedback_off,
  input wire logic        valve_up_q,
  input wire logic        valve_down_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cfg_q;

  // mirror of configuration; writes refused for their options or source leave it alone, writes refused outside idle still update it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cfg_q <= '0;
    else if (psel && penable && pwrite && paddr == PSS_REG_CFG && !(pwdata[0] && pwdata[1])
             && (!(pwdata[0] || pwdata[1]) || pwdata[9:8] <= (pwdata[1] ? 2'h2 : 2'h1)))
      cfg_q <= pwdata[5:0];
  end

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  AST_EXCL: assert property (!(valve_up_q && valve_down_q))
    else $error("up and down valves on together");
  AST_STOP: assert property (!nonmutable_safety_stop |=> !valve_up_q && !valve_down_q)
    else $error("valve on after safety stop");
  AST_BOT: assert property (valve_down_q && bottom_stroke_limit |=> !valve_down_q)
    else $error("down valve kept past bottom");
  AST_TOP: assert property (valve_up_q && top_stroke_limit |=> !valve_up_q)
    else $error("up valve kept past top");
  AST_RETURN: assert property ($rose(nonmutable_safety_stop) |-> (!valve_up_q && !valve_down_q) [*3])
    else $error("motion restarted by safety return");
  AST_HELD: assert property (cfg_q[CFG_HELD_UP] && $fell(cycle_cmd) |=> !valve_up_q && !valve_down_q)
    else $error("motion kept after command release");
  AST_CL_DOWN: assert property (cfg_q[CFG_CL_UP] && $rose(valve_down_q) |-> $past(up_feedback_off))
    else $error("down valve on before up valve verified off");
  AST_CL_UP: assert property (cfg_q[CFG_CL_DOWN] && $rose(valve_up_q) |-> $past(down_feedback_off))
    else $error("up valve on before down valve verified off");
endmodule

bind press_stroke_sequencer pss_monitor pss_monitor_i (.*);

// [tb/pss_plant.sv]
module pss_plant #(
  parameter int POS_MAX = 40,
  parameter int FB_LAG  = 3
)
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic valve_up_q,
  input  wire logic valve_down_q,
  output logic      top_stroke_limit,
  output logic      bottom_stroke_limit,
  output logic      up_feedback_off,
  output logic      down_feedback_off
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos;
  int up_off;
  int dn_off;

  // slide moves one step a cycle; valves report off only after a lag
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pos    <= 0;
      up_off <= FB_LAG;
      dn_off <= FB_LAG;
    end
    else
    begin
      if (valve_down_q && pos < POS_MAX)
        pos <= pos + 1;
      else if (valve_up_q && pos > 0)
        pos <= pos - 1;
      up_off <= valve_up_q ? 0 : (up_off < FB_LAG ? up_off + 1 : up_off);
      dn_off <= valve_down_q ? 0 : (dn_off < FB_LAG ? dn_off + 1 : dn_off);
    end
  end

  assign top_stroke_limit    = (pos == 0);
  assign bottom_stroke_limit = (pos == POS_MAX);
  assign up_feedback_off     = (up_off >= FB_LAG);
  assign down_feedback_off   = (dn_off >= FB_LAG);
endmodule

// [tb/press_stroke_sequencer_tb.sv]
module press_stroke_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pss_pkg::*;
  logic        clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [63:0] note, note_q[$];
  logic        pready, pslverr, valve_up_q, valve_down_q, top_stroke_limit;
  logic        bottom_stroke_limit, up_feedback_off, down_feedback_off;
  logic        cycle_cmd = 0, press_reset = 0, nonmutable_safety_stop = 1, mode_inch_down = 0;
  logic        mode_run = 0, mode_inch_up = 0, part_present_input = 1, mutable_safety_stop = 1;
  int          failures = 0, tests_run = 0, up_cnt = 0, dn_cnt = 0, c0, on_t, per;
  integer      seed = 35494;

  press_stroke_sequencer press_stroke_sequencer_i (.*);
  pss_plant pss_plant_i (.*);

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    up_cnt <= up_cnt + int'(valve_up_q === 1'b1);
    dn_cnt <= dn_cnt + int'(valve_down_q === 1'b1);
    if (psel && penable && pready === 1'b1)
      cmp("pslverr", 32'h0, 32'(pslverr));
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      note = note_q.pop_front();
      cmp("prdata", note[31:0], prdata & note[63:32]);
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel    <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    note_q.push_back({m, e & m});
    apb(0, a, '0);
  endtask

  task automatic rst;
    sys_rst <= 1;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 0;
    @(posedge clk_sys);
  endtask

  task automatic start;
    press_reset <= 1;
    @(posedge clk_sys);
    press_reset <= 0;
    cycle_cmd   <= 1;
    for (int i = 0; i < 200 && valve_down_q !== 1'b1; i++) @(posedge clk_sys);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    rst();
    rd(PSS_REG_CFG, 32'h0);
    rd(PSS_REG_INCHP, 32'h0);
    rd(12'h010, 32'h0);
    apb(1, PSS_REG_CFG, 32'h3);
    rd(PSS_REG_STATUS, 32'h1, 32'h1);
    for (int s = 0; s < 8; s++)
    begin
      apb(1, PSS_REG_CFG, {s[1:0], 8'h30} | (s[2] ? 32'h2 : 32'h1));
      rd(PSS_REG_STATUS, 32'(s[1:0] > (s[2] ? 2 : 1)), 32'h1);
    end
    rd(PSS_REG_CFG, 32'h232);
    start();
    cycle_cmd <= 0;
    for (int i = 0; i < 500 && !(up_cnt > 0 && top_stroke_limit && !valve_up_q); i++)
      @(posedge clk_sys);
    cmp("upstroke", 32'h1, 32'(up_cnt > 0));
    rd(PSS_REG_STATUS, 32'(PSS_IDLE) << 8, 32'h3f30);
    rst();
    apb(1, PSS_REG_CFG, 32'h1);
    start();
    cycle_cmd <= 0;
    repeat (2) @(posedge clk_sys);
    rd(PSS_REG_STATUS, 32'h0, 32'h30);
    rst();
    apb(1, PSS_REG_CFG, 32'h2);
    start();
    cycle_cmd              <= 0;
    nonmutable_safety_stop <= 0;
    repeat (2) @(posedge clk_sys);
    nonmutable_safety_stop <= 1;
    @(posedge clk_sys);
    cycle_cmd <= 1; // fresh press after the stop, with no re-arm
    repeat (3) @(posedge clk_sys);
    rd(PSS_REG_STATUS, 32'h0, 32'h34);
    cycle_cmd <= 0;
    rd(PSS_REG_STATUS, 32'h0, 32'h34);
    rst();
    on_t = 4 + ($unsigned($random(seed)) % 4);
    per  = on_t + 3 + ($unsigned($random(seed)) % 4);
    apb(1, PSS_REG_CFG, 32'h5);
    apb(1, PSS_REG_INCHP, per);
    apb(1, PSS_REG_INCHON, on_t);
    rd(PSS_REG_INCHP, per);
    start();
    rd(PSS_REG_STATUS, 32'h2, 32'h32);
    cycle_cmd      <= 0;
    mode_inch_down <= 1;
    @(posedge clk_sys);
    start();
    c0 = dn_cnt;
    repeat (3 * per) @(posedge clk_sys);
    cmp("inch on cycles", 3 * on_t, dn_cnt - c0);
    cycle_cmd      <= 0;
    mode_inch_down <= 0;
    mode_inch_up   <= 1;
    repeat (2) @(posedge clk_sys);
    c0        = up_cnt;
    cycle_cmd <= 1;
    repeat (per + 3) @(posedge clk_sys);
    cmp("inch up cycles", on_t, up_cnt - c0);
    cycle_cmd <= 0;
    rst();
    apb(1, PSS_REG_CFG, 32'ha);
    start();
    cycle_cmd <= 0;
    for (int i = 0; i < 200 && valve_up_q !== 1'b1; i++) @(posedge clk_sys);
    mutable_safety_stop <= 0;
    for (int i = 0; i < 200 && !(top_stroke_limit && !valve_up_q); i++) @(posedge clk_sys);
    cmp("top reached with mute", 32'h1, 32'(top_stroke_limit));
    mutable_safety_stop <= 1;
    cycle_cmd           <= 1; // part not cycled since bottom
    repeat (4) @(posedge clk_sys);
    rd(PSS_REG_STATUS, 32'h0, 32'h38);
    cycle_cmd          <= 0;
    part_present_input <= 0;
    @(posedge clk_sys);
    part_present_input <= 1;
    repeat (2) @(posedge clk_sys);
    rd(PSS_REG_STATUS, 32'h8, 32'h8);
    start();
    cmp("restart after part change", 32'h1, 32'(valve_down_q === 1'b1));
    cycle_cmd <= 0;
    summarize();
  end

  // hang guard, far beyond the few hundred cycles the scenarios need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule
